/* sep_pkg.sv */
// Functional notes
// - Chip select low: ignore link, output tri-stated
// - Chip select fall resets command state, rise enables
// - Started programming always runs to completion
// - Programming status shown busy low, ready high
// - Select toggling during programming never disturbs it
// - Start bit or select low clears ready
// - Falling select never starts programming
// - Strap high 16-bit/10 addr, low 8-bit/11
// - Strap reads as 16-bit words from reset until the second link clock rise carries the pin through
// - Input sampled, output advanced on rising clock
// - Serial clock not needed for programming or status polling
// - First one after select rise is start
// - Read data shifts out after last address
// - Start, two-bit opcode, address; opcodes decoded
// - Special enable on 11, disable on 00
// - Write carries one word, MSB first
// - Special 01 fills all, 10 erases all
// - Erase sets every targeted bit to one
// - Programming starts on last command bit edge
// - Powers up disabled; enable persists until disable
// - Read sends one dummy zero before data
package sep_pkg;

  // ==========================================================
  // Field widths
  localparam int ADDR_W_WIDE = 10;
  localparam int ADDR_W_NARROW = 11;
  localparam int DATA_W_WIDE = 16;
  localparam int DATA_W_NARROW = 8;
  localparam int CNT_W = 5;
  localparam logic [CNT_W-1:0] OPC_LAST = CNT_W'(1);
  localparam logic [CNT_W-1:0] ADDR_LAST_WIDE = CNT_W'(ADDR_W_WIDE - 1);
  localparam logic [CNT_W-1:0] ADDR_LAST_NARROW = CNT_W'(ADDR_W_NARROW - 1);
  localparam logic [CNT_W-1:0] DATA_LAST_WIDE = CNT_W'(DATA_W_WIDE - 1);
  localparam logic [CNT_W-1:0] DATA_LAST_NARROW = CNT_W'(DATA_W_NARROW - 1);
  localparam logic [CNT_W-1:0] DATA_LEN_WIDE = CNT_W'(DATA_W_WIDE);
  localparam logic [CNT_W-1:0] DATA_LEN_NARROW = CNT_W'(DATA_W_NARROW);

  // ==========================================================
  // Opcodes and leading address bits of special commands
  localparam logic [1:0] OPC_READ = 2'h2;
  localparam logic [1:0] OPC_WRITE = 2'h1;
  localparam logic [1:0] OPC_ERASE = 2'h3;
  localparam logic [1:0] OPC_SPECIAL = 2'h0;
  localparam logic [1:0] LEAD_ENABLE = 2'h3;
  localparam logic [1:0] LEAD_DISABLE = 2'h0;
  localparam logic [1:0] LEAD_FILL = 2'h1;
  localparam logic [1:0] LEAD_WIPE = 2'h2;

  // ==========================================================
  // Array and values
  localparam int WORD_DEPTH = 1024;
  localparam int WIDX_W = 10;
  localparam int SWEEP_W = 11;
  localparam logic [SWEEP_W-1:0] SWEEP_LAST = SWEEP_W'(WORD_DEPTH - 1);
  localparam logic [15:0] ERASED_WORD = 16'hFFFF;
  localparam logic [7:0] PAD_BYTE = 8'h00;
  localparam logic DUMMY_BIT = 1'b0;
  localparam logic STRAP_DEFAULT = 1'b1;

  // ==========================================================
  // Timing: self-timed programming, longest time rounds down
  localparam int CLK_HZ = 40_000_000;
  localparam int T_WP_MS = 15;
  localparam int T_WP_CYC = T_WP_MS * (CLK_HZ / 1000);

  // ==========================================================
  // Types
  typedef enum logic [5:0] {
    ST_IDLE = 6'h01,
    ST_OPC = 6'h02,
    ST_ADDR = 6'h04,
    ST_DATA = 6'h08,
    ST_READ = 6'h10,
    ST_DONE = 6'h20
  } sep_state_t;

  typedef enum logic [1:0] {
    PK_WRITE = 2'h0,
    PK_ERASE = 2'h1,
    PK_FILL = 2'h2,
    PK_WIPE = 2'h3
  } sep_prog_t;

endpackage

/* sep_sync.sv */
`timescale 1ns/1ps
// Two-flop level synchroniser; first stage feeds only the second
module sep_sync #(
  parameter int W = 1,
  parameter logic [W-1:0] RST_VAL = '0
) (
  // Destination clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Level in, synchronised level out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta;

  // Reset acts without a clock so a stopped link clock still settles
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      meta <= RST_VAL;
      q_o <= RST_VAL;
    end else begin
      meta <= d_i;
      q_o <= meta;
    end
  end

endmodule

/* sep_cmd_port.sv */
`timescale 1ns/1ps
module sep_cmd_port #(
  parameter int TWP_CYC = sep_pkg::T_WP_CYC
) (
  // System clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Serial link pins
  input wire logic serial_clock_i,
  input wire logic chip_select_i,
  input wire logic serial_in_i,
  input wire logic word_width_strap_i,
  output logic serial_out_o,
  output logic serial_out_oe_o,
  // Status
  output logic busy_o,
  output logic program_enabled_o
);
  import sep_pkg::*;

  localparam int TMR_W = $clog2(TWP_CYC + 1);

  // ==========================================================
  // Elaboration check: the sweep must fit inside the write time
  if (TWP_CYC < WORD_DEPTH + 1) begin : g_bad_twp
    $error("TWP_CYC too small for a full-array sweep");
  end

  // ==========================================================
  // Array, written only from the system clock domain
  logic [15:0] mem [WORD_DEPTH];

  // Link domain signals
  sep_state_t state;
  logic [1:0] opc;
  logic [CNT_W-1:0] cnt;
  logic [10:0] addr_sh;
  logic [15:0] data_sh;
  logic [15:0] rd_sh;
  logic rd_bit;
  logic rd_drive;
  logic prog_tog;
  logic start_tog;
  logic prog_en;
  sep_prog_t hold_kind;
  logic [10:0] hold_addr;
  logic [15:0] hold_data;
  logic hold_org;
  logic org_l;
  logic busy_l;
  logic ack_l;
  logic link_busy;

  // Link combinational decode
  logic [10:0] a_full;
  logic [15:0] d_full;
  logic [1:0] lead;
  logic addr_last;
  logic data_last;
  logic [WIDX_W-1:0] widx;
  logic [15:0] rd_word;
  logic [15:0] rd_load;
  logic fire;
  sep_prog_t kind;
  logic en_set;
  logic en_clr;
  logic want_data;

  // System domain signals
  logic cs_s;
  logic req_s;
  logic start_s;
  logic req_seen;
  logic start_seen;
  logic busy;
  logic show;
  logic sweeping;
  logic [SWEEP_W-1:0] sweep;
  logic [TMR_W-1:0] tmr;
  sep_prog_t p_kind;
  logic [10:0] p_addr;
  logic [15:0] p_data;
  logic p_org;
  logic wr_en;
  logic [WIDX_W-1:0] wr_idx;
  logic [15:0] wr_word;
  logic [15:0] wr_fill;

  // ==========================================================
  // Crossings into the link domain
  sep_sync #(.W(1), .RST_VAL(STRAP_DEFAULT)) u_org_sync (
    .clk_i(serial_clock_i),
    .rst_i(rst_i),
    .d_i(word_width_strap_i),
    .q_o(org_l)
  );

  sep_sync #(.W(2), .RST_VAL(2'h0)) u_busy_sync (
    .clk_i(serial_clock_i),
    .rst_i(rst_i),
    .d_i({busy, req_seen}),
    .q_o({busy_l, ack_l})
  );

  // Pending request counts as busy until the other side echoes it
  assign link_busy = busy_l | (prog_tog != ack_l);

  // ==========================================================
  // Link field decode
  always_comb begin
    a_full = {addr_sh[9:0], serial_in_i};
    d_full = {data_sh[14:0], serial_in_i};
    lead = org_l ? a_full[9:8] : a_full[10:9];
    addr_last = (cnt == (org_l ? ADDR_LAST_WIDE : ADDR_LAST_NARROW));
    data_last = (cnt == (org_l ? DATA_LAST_WIDE : DATA_LAST_NARROW));
    widx = org_l ? a_full[9:0] : a_full[10:1];
    rd_word = mem[widx];
    // Byte reads are left-aligned so the shifter always sends MSB first
    if (org_l) begin
      rd_load = rd_word;
    end else if (a_full[0]) begin
      rd_load = {rd_word[15:8], PAD_BYTE};
    end else begin
      rd_load = {rd_word[7:0], PAD_BYTE};
    end
    want_data = (opc == OPC_WRITE) || ((opc == OPC_SPECIAL) && (lead == LEAD_FILL));
    fire = 1'b0;
    kind = PK_WRITE;
    en_set = 1'b0;
    en_clr = 1'b0;
    if ((state == ST_ADDR) && addr_last) begin
      if (opc == OPC_ERASE) begin
        fire = prog_en && !link_busy;
        kind = PK_ERASE;
      end else if (opc == OPC_SPECIAL) begin
        if (lead == LEAD_ENABLE) begin
          en_set = 1'b1;
        end else if (lead == LEAD_DISABLE) begin
          en_clr = 1'b1;
        end else if (lead == LEAD_WIPE) begin
          fire = prog_en && !link_busy;
          kind = PK_WIPE;
        end
      end
    end else if ((state == ST_DATA) && data_last) begin
      fire = prog_en && !link_busy;
      kind = (opc == OPC_WRITE) ? PK_WRITE : PK_FILL;
    end
  end

  // ==========================================================
  // Command sequencer; select low clears it at once
  always_ff @(posedge serial_clock_i or negedge chip_select_i) begin
    if (!chip_select_i) begin
      state <= ST_IDLE;
      opc <= OPC_SPECIAL;
      cnt <= '0;
      addr_sh <= '0;
      data_sh <= '0;
      rd_sh <= '0;
      rd_bit <= DUMMY_BIT;
      rd_drive <= 1'b0;
    end else begin
      case (state)
        ST_IDLE: begin
          if (serial_in_i) begin
            state <= ST_OPC;
            cnt <= '0;
          end
        end
        ST_OPC: begin
          opc <= {opc[0], serial_in_i};
          if (cnt == OPC_LAST) begin
            state <= ST_ADDR;
            cnt <= '0;
          end else begin
            cnt <= cnt + 1'b1;
          end
        end
        ST_ADDR: begin
          addr_sh <= a_full;
          cnt <= addr_last ? '0 : cnt + 1'b1;
          if (addr_last) begin
            if ((opc == OPC_READ) && !link_busy) begin
              state <= ST_READ;
              rd_drive <= 1'b1;
              rd_bit <= DUMMY_BIT;
              rd_sh <= rd_load;
            end else if (want_data && prog_en && !link_busy) begin
              state <= ST_DATA;
            end else begin
              state <= ST_DONE;
            end
          end
        end
        ST_DATA: begin
          data_sh <= d_full;
          cnt <= cnt + 1'b1;
          if (data_last) begin
            state <= ST_DONE;
          end
        end
        ST_READ: begin
          if (cnt == (org_l ? DATA_LEN_WIDE : DATA_LEN_NARROW)) begin
            state <= ST_DONE;
            rd_drive <= 1'b0;
          end else begin
            rd_bit <= rd_sh[15];
            rd_sh <= {rd_sh[14:0], DUMMY_BIT};
            cnt <= cnt + 1'b1;
          end
        end
        ST_DONE: begin
          state <= ST_DONE;
        end
        default: begin
          state <= ST_IDLE;
        end
      endcase
    end
  end

  // ==========================================================
  // Link state that survives select low: enable, hand-off, toggles
  always_ff @(posedge serial_clock_i or posedge rst_i) begin
    if (rst_i) begin
      prog_en <= 1'b0;
      prog_tog <= 1'b0;
      start_tog <= 1'b0;
      hold_kind <= PK_WRITE;
      hold_addr <= '0;
      hold_data <= '0;
      hold_org <= STRAP_DEFAULT;
    end else begin
      if (en_set) begin
        prog_en <= 1'b1;
      end else if (en_clr) begin
        prog_en <= 1'b0;
      end
      // A one after a finished command also counts, so status clears with select held
      if (chip_select_i && ((state == ST_IDLE) || (state == ST_DONE)) && serial_in_i) begin
        start_tog <= ~start_tog;
      end
      // Holding words stay put while the request is pending
      if (fire) begin
        prog_tog <= ~prog_tog;
        hold_kind <= kind;
        hold_addr <= (state == ST_ADDR) ? a_full : addr_sh;
        hold_data <= d_full;
        hold_org <= org_l;
      end
    end
  end

  // ==========================================================
  // Crossings into the system domain
  sep_sync #(.W(3), .RST_VAL(3'h0)) u_sys_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i({chip_select_i, prog_tog, start_tog}),
    .q_o({cs_s, req_s, start_s})
  );

  sep_sync #(.W(1), .RST_VAL(1'b0)) u_en_sync (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .d_i(prog_en),
    .q_o(program_enabled_o)
  );

  // ==========================================================
  // Array write data; byte-mode write and erase merge into the stored word
  always_comb begin
    if ((p_kind == PK_ERASE) || (p_kind == PK_WIPE)) begin
      wr_fill = ERASED_WORD;
    end else if (p_org) begin
      wr_fill = p_data;
    end else begin
      wr_fill = {p_data[7:0], p_data[7:0]};
    end
    wr_en = busy && sweeping;
    if ((p_kind == PK_FILL) || (p_kind == PK_WIPE)) begin
      wr_idx = sweep[WIDX_W-1:0];
      wr_word = wr_fill;
    end else if (p_org) begin
      wr_idx = p_addr[9:0];
      wr_word = wr_fill;
    end else begin
      wr_idx = p_addr[10:1];
      wr_word = p_addr[0] ? {wr_fill[15:8], mem[p_addr[10:1]][7:0]}
                          : {mem[p_addr[10:1]][15:8], wr_fill[7:0]};
    end
  end

  // Array port
  always_ff @(posedge clk_i) begin
    if (wr_en) begin
      mem[wr_idx] <= wr_word;
    end
  end

  // ==========================================================
  // Self-timed programming engine, system clock only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      req_seen <= 1'b0;
      busy <= 1'b0;
      sweeping <= 1'b0;
      sweep <= '0;
      tmr <= '0;
      p_kind <= PK_WRITE;
      p_addr <= '0;
      p_data <= '0;
      p_org <= STRAP_DEFAULT;
    end else if (req_s != req_seen) begin
      req_seen <= req_s;
      busy <= 1'b1;
      sweeping <= 1'b1;
      sweep <= '0;
      tmr <= TMR_W'(TWP_CYC - 1);
      p_kind <= hold_kind;
      p_addr <= hold_addr;
      p_data <= hold_data;
      p_org <= hold_org;
    end else if (busy) begin
      // Select and serial clock are not looked at here
      if (sweeping) begin
        sweep <= sweep + 1'b1;
        if ((p_kind == PK_WRITE) || (p_kind == PK_ERASE) || (sweep == SWEEP_LAST)) begin
          sweeping <= 1'b0;
        end
      end
      tmr <= tmr - 1'b1;
      if (tmr == '0) begin
        busy <= 1'b0;
      end
    end
  end

  // Status display flag; a new start wins over a clear
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      show <= 1'b0;
      start_seen <= 1'b0;
    end else begin
      start_seen <= start_s;
      if (req_s != req_seen) begin
        show <= 1'b1;
      end else if (!busy && (!cs_s || (start_s != start_seen))) begin
        show <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Pin drive: status has priority, tri-state while deselected
  assign serial_out_o = show ? ~busy : rd_bit;
  assign serial_out_oe_o = cs_s & (show | rd_drive);
  assign busy_o = busy;

endmodule

/* sep_cmd_port_props.sv */
`timescale 1ns/1ps
// ==========
// Port checker, system clock domain
module sep_cmd_port_props #(
  parameter int TWP_CYC = 600000
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link pins
  input wire logic serial_clock_i,
  input wire logic chip_select_i,
  input wire logic serial_in_i,
  input wire logic word_width_strap_i,
  input wire logic serial_out_o,
  input wire logic serial_out_oe_o,
  // Status
  input wire logic busy_o,
  input wire logic program_enabled_o
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  int busy_len;
  // Busy length, judged when busy ends
  always_ff @(posedge clk_i) begin
    busy_len <= (rst_i || !busy_o) ? 0 : busy_len + 1;
  end
  property p_float;
    !chip_select_i [*4] |-> !serial_out_oe_o;
  endproperty
  a_float: assert property (p_float) else $error("output driven, select low");
  property p_por;
    $fell(rst_i) |-> !busy_o && !program_enabled_o && !serial_out_oe_o;
  endproperty
  a_por: assert property (p_por) else $error("bad state after reset");
  property p_busy_low;
    busy_o && $past(busy_o, 2) && serial_out_oe_o |-> !serial_out_o;
  endproperty
  a_busy_low: assert property (p_busy_low) else $error("busy not shown low");
  property p_ready;
    $fell(busy_o) && serial_out_oe_o |-> ##[1:4] serial_out_o;
  endproperty
  a_ready: assert property (p_ready) else $error("ready not shown high");
  property p_len;
    $fell(busy_o) |-> busy_len inside {[TWP_CYC - 3:TWP_CYC + 3]};
  endproperty
  a_len: assert property (p_len) else $error("busy length wrong");
  property p_need_en;
    $rose(busy_o) |-> program_enabled_o;
  endproperty
  a_need_en: assert property (p_need_en) else $error("program while disabled");
  property p_no_fall;
    $rose(busy_o) |-> chip_select_i && $past(chip_select_i, 3);
  endproperty
  a_no_fall: assert property (p_no_fall) else $error("program on select fall");
  property p_en_cs;
    $changed(program_enabled_o) |-> $past(chip_select_i, 2);
  endproperty
  a_en_cs: assert property (p_en_cs) else $error("enable moved off frame");
  // Main scenarios reached
  c_prog: cover property ($rose(busy_o));
  c_ready: cover property ($fell(busy_o) && serial_out_oe_o);
  c_en: cover property ($rose(program_enabled_o));
endmodule

bind sep_cmd_port sep_cmd_port_props #(.TWP_CYC(TWP_CYC)) u_props (
  .clk_i(clk_i), .rst_i(rst_i), .serial_clock_i(serial_clock_i),
  .chip_select_i(chip_select_i), .serial_in_i(serial_in_i),
  .word_width_strap_i(word_width_strap_i), .serial_out_o(serial_out_o),
  .serial_out_oe_o(serial_out_oe_o), .busy_o(busy_o),
  .program_enabled_o(program_enabled_o));

/* sep_host.sv */
`timescale 1ns/1ps
// ==========
// Host model; link clock stands still outside frames
module sep_host (
  // Link pins towards the device
  output logic sk_o,
  output logic cs_o,
  output logic di_o,
  // Wire level of the device output
  input wire logic so_i
);
  initial begin
    sk_o = 1'b0;
    cs_o = 1'b0;
    di_o = 1'b0;
  end
  // Select held high over the whole frame; sample just before each rise
  task automatic xfer(input logic [39:0] tx, input int n, output logic [39:0] rx);
    rx = '0;
    #13 cs_o = 1'b1;
    for (int i = n - 1; i >= 0; i--) begin
      di_o = tx[i];
      #60 rx = {rx[38:0], so_i};
      #2.5 sk_o = 1'b1;
      #62.5 sk_o = 1'b0;
    end
    di_o = 1'b0;
    #200;
  endtask
  // Select low ends a frame or a status poll
  task automatic drop();
    cs_o = 1'b0;
    #300;
  endtask
  // Select high alone, to poll status
  task automatic sel();
    cs_o = 1'b1;
    #300;
  endtask
endmodule

/* serial_eeprom_command_port_test.sv */
`timescale 1ns/1ps
// ==========
// Self-checking bench, link driven by the host model
module serial_eeprom_command_port_test;
  import sep_pkg::*;
  localparam int TWP = 1100;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic strap = 1'b1;
  logic sk, cs, di, so, oe, busy, en;
  wire so_w = oe ? so : 1'bz;
  int errors = 0;
  int tests_run = 0;
  logic [39:0] rx;
  logic [15:0] d;
  sep_cmd_port #(.TWP_CYC(TWP)) uut (.clk_i(clk_i), .rst_i(rst_i), .serial_clock_i(sk),
    .chip_select_i(cs), .serial_in_i(di), .word_width_strap_i(strap), .serial_out_o(so),
    .serial_out_oe_o(oe), .busy_o(busy), .program_enabled_o(en));
  sep_host host (.sk_o(sk), .cs_o(cs), .di_o(di), .so_i(so_w));
  // 40 MHz system clock
  initial begin
    forever #12.5 clk_i = ~clk_i;
  end
  // ==========
  // Helpers
  task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  // op carries start bit and opcode; select stays high afterwards
  task automatic send(input logic [2:0] op, input logic [10:0] a, input int aw,
                      input logic [15:0] dv, input int dl);
    host.xfer(((40'(op) << aw | 40'(a)) << dl) | 40'(dv), 3 + aw + dl, rx);
  endtask
  // Read with one leading zero ahead of the start bit
  task automatic rd(input logic [10:0] a, input int aw, input int dw, output logic [15:0] q);
    host.xfer((40'h6 << aw | 40'(a)) << (dw + 1), 5 + aw + dw, rx);
    chk("pre-data float", 16'(1'bz), 16'(rx[dw + 1]));
    chk("dummy bit", 16'h0000, 16'(rx[dw]));
    chk("released", 16'h0000, 16'(oe));
    q = rx[15:0] & ((16'h1 << dw) - 16'h1);
    host.drop();
  endtask
  // Poll ready with select high, bounded
  task automatic wait_ready(input bit keep);
    int k;
    for (k = 0; k < 3000 && !(oe === 1'b1 && so === 1'b1); k++) begin
      @(negedge clk_i);
    end
    if (k == 3000) begin
      errors++;
      end_sim();
    end
    chk("busy after ready", 16'h0000, 16'(busy));
    if (!keep) begin
      host.drop();
    end
  endtask
  // ==========
  // Scenarios
  task automatic t_reset();
    chk("busy", 16'h0000, 16'(busy));
    chk("enabled", 16'h0000, 16'(en));
    chk("oe", 16'h0000, 16'(oe));
    $display("reset test done");
  endtask
  task automatic t_enable();
    send(3'h5, 11'h005, 10, 16'h1234, 16);
    host.drop();
    chk("busy while disabled", 16'h0000, 16'(busy));
    send(3'h4, 11'h300, 10, 16'h0000, 0);
    chk("enabled", 16'h0001, 16'(en));
    host.drop();
    $display("enable test done");
  endtask
  task automatic t_write();
    send(3'h5, 11'h155, 10, 16'hA5C3, 16);
    chk("busy", 16'h0001, 16'(busy));
    chk("status", 16'h0000, 16'({oe, so} ^ 2'h2));
    host.drop();
    chk("oe select low", 16'h0000, 16'(oe));
    host.sel();
    chk("poll status", 16'h0000, 16'({oe, so, busy} ^ 3'h5));
    wait_ready(1'b1);
    host.xfer(40'h1, 1, rx);
    chk("cleared by start", 16'h0000, 16'(oe));
    host.drop();
    rd(11'h155, 10, 16, d);
    chk("word", 16'hA5C3, d);
    $display("write test done");
  endtask
  task automatic t_abort();
    host.xfer(((40'h5 << 10 | 40'h155) << 16) >> 1, 28, rx);
    host.drop();
    repeat (10) @(negedge clk_i);
    chk("busy after abort", 16'h0000, 16'(busy));
    rd(11'h155, 10, 16, d);
    chk("word kept", 16'hA5C3, d);
    $display("abort test done");
  endtask
  task automatic t_erase_bytes();
    send(3'h7, 11'h155, 10, 16'h0000, 0);
    wait_ready(1'b0);
    rd(11'h155, 10, 16, d);
    chk("erased", ERASED_WORD, d);
    @(negedge clk_i) strap = 1'b0;
    repeat (10) @(negedge clk_i);
    send(3'h5, 11'h2AB, 11, 16'h003C, 8);
    wait_ready(1'b0);
    rd(11'h2AB, 11, 8, d);
    chk("upper byte", 16'h003C, d);
    rd(11'h2AA, 11, 8, d);
    chk("lower byte", 16'h00FF, d);
    @(negedge clk_i) strap = 1'b1;
    repeat (10) @(negedge clk_i);
    $display("erase and byte test done");
  endtask
  task automatic t_all();
    send(3'h4, 11'h100, 10, 16'h5A69, 16);
    wait_ready(1'b0);
    rd(11'h000, 10, 16, d);
    chk("fill low", 16'h5A69, d);
    rd(11'h3FF, 10, 16, d);
    chk("fill high", 16'h5A69, d);
    send(3'h4, 11'h200, 10, 16'h0000, 0);
    wait_ready(1'b0);
    rd(11'h3FF, 10, 16, d);
    chk("wiped", ERASED_WORD, d);
    send(3'h4, 11'h000, 10, 16'h0000, 0);
    host.drop();
    chk("disabled", 16'h0000, 16'(en));
    send(3'h7, 11'h001, 10, 16'h0000, 0);
    chk("erase refused", 16'h0000, 16'(busy));
    host.drop();
    $display("all-words test done");
  endtask
  // ==========
  // Main sequence
  initial begin
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    repeat (5) @(negedge clk_i);
    t_reset();
    t_enable();
    t_write();
    t_abort();
    t_erase_bytes();
    t_all();
    end_sim();
  end
endmodule
